// file: tcm_pkg.sv
// Package with the constants, carriers and register map of the 16-bit compare timer
// Behaviour
// - Compare full count each cycle; flag next tick
// - Enabled flag requests interrupt; ack or one clears
// - Compare double-buffered in PWM, direct otherwise
// - Buffered value loads active only at TOP
// - Processor access reaches buffer or active register
// - Compare high byte read directly, no latch
// - High byte to latch; low write copies both
// - Force strobe updates output outside PWM only, no flag, no clear
// - Counter write blocks matches on next tick
// - Counter written at variable TOP misses TOP
// - Action bits unbuffered, apply at next match
// - Reset clears each output bit
// - Output bit kept across mode changes
// - Nonzero action overrides port value, direction untouched
// - Action zero leaves output bit unchanged
// - Action bits never touch input capture
// - Mode bits set counting; action bits set output
// - Channel A value may serve as TOP
// - Normal mode counts up, wraps to zero
// - Normal overflow flag set when count reaches zero
// - Clear-on-match clears at tick after TOP match
// - Counter write beats count and clear
// - Clear-on-match overflow set on MAX to zero
package tcm_pkg;

  // ****************************************
  // Register offsets on the byte port
  // ****************************************
  localparam logic [3:0] TCM_OFF_CTRL_A = 4'h0; // Actions and low mode bits
  localparam logic [3:0] TCM_OFF_CTRL_B = 4'h1; // High mode bits and run
  localparam logic [3:0] TCM_OFF_FORCE = 4'h2; // Force strobes, reads zero
  localparam logic [3:0] TCM_OFF_IRQ_EN = 4'h3; // Interrupt enables
  localparam logic [3:0] TCM_OFF_FLAGS = 4'h4; // Sticky flags, write one clears
  localparam logic [3:0] TCM_OFF_CNT_L = 4'h5;
  localparam logic [3:0] TCM_OFF_CNT_H = 4'h6;
  localparam logic [3:0] TCM_OFF_CMPA_L = 4'h7;
  localparam logic [3:0] TCM_OFF_CMPA_H = 4'h8;
  localparam logic [3:0] TCM_OFF_CMPB_L = 4'h9;
  localparam logic [3:0] TCM_OFF_CMPB_H = 4'ha;
  localparam logic [3:0] TCM_OFF_CAP_L = 4'hb;
  localparam logic [3:0] TCM_OFF_CAP_H = 4'hc;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TCM_ACT_A_POS = 6; // CTRL_A [7:6]
  localparam int TCM_ACT_B_POS = 4; // CTRL_A [5:4]
  localparam int TCM_MODE_LO_POS = 0; // CTRL_A [1:0]
  localparam int TCM_MODE_HI_POS = 3; // CTRL_B [4:3]
  localparam int TCM_RUN_POS = 0; // CTRL_B [0]
  localparam int TCM_FORCE_A_POS = 7; // FORCE [7]
  localparam int TCM_FORCE_B_POS = 6; // FORCE [6]

  // ****************************************
  // Reset values and counter landmarks
  // ****************************************
  localparam logic [7:0] TCM_RESET_BYTE = 8'h00;
  localparam logic [15:0] TCM_RESET_WORD = 16'h0000;
  localparam logic [15:0] TCM_COUNT_MAX = 16'hffff;
  localparam logic [15:0] TCM_COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TCM_TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TCM_TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TCM_TOP_10BIT = 16'h03ff;

  // ****************************************
  // Waveform modes with special meaning
  // ****************************************
  localparam logic [3:0] TCM_MODE_NORMAL = 4'h0;
  localparam logic [3:0] TCM_MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] TCM_MODE_CTC_CAP = 4'hc;
  localparam logic [3:0] TCM_MODE_RESERVED = 4'hd;

  // Output actions
  localparam logic [1:0] TCM_ACT_NONE = 2'h0;
  localparam logic [1:0] TCM_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TCM_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TCM_ACT_SET = 2'h3;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] addr; // Register offset
    logic [7:0] wdata; // Write byte
    logic wr; // Write strobe
    logic rd; // Read strobe
  } tcm_bus_req_t;

  typedef struct packed {
    logic match_b; // Bit 2
    logic match_a; // Bit 1
    logic ovf; // Bit 0
  } tcm_flags_t;

endpackage

// file: tcm_compare_channel.sv
// One compare channel: active and buffer registers, equality and output bit
`timescale 1ns/100ps
module tcm_compare_channel import tcm_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_en, // Low-byte write completes a word
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic buffered, // PWM mode in force
  input wire logic reload, // Counter at TOP in PWM
  input wire logic [WIDTH-1:0] count,
  input wire logic match_evt, // Qualified match on a tick
  input wire logic force_evt, // Force strobe, non-PWM only
  input wire logic bottom_evt, // PWM wrap to BOTTOM
  input wire logic [1:0] action,
  output logic [WIDTH-1:0] active_value,
  output logic [WIDTH-1:0] cpu_view,
  output logic equal,
  output logic out_bit
);

  logic [WIDTH-1:0] active_reg; // Value the comparator sees
  logic [WIDTH-1:0] buffer_reg; // Staging value in PWM modes

  // Buffer always takes writes so a mode switch finds it current
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buffer_reg <= TCM_RESET_WORD;
    end else if (wr_en) begin
      buffer_reg <= wr_data;
    end
  end

  // Active register: direct writes outside PWM, TOP reload inside
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      active_reg <= TCM_RESET_WORD;
    end else if (!buffered && wr_en) begin
      active_reg <= wr_data;
    end else if (buffered && reload) begin
      active_reg <= buffer_reg;
    end
  end

  assign active_value = active_reg;
  assign cpu_view = buffered ? buffer_reg : active_reg;
  assign equal = (count == active_reg);

  // Output bit; action read live so changes apply at the next match
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_bit <= 1'b0;
    end else if (match_evt || force_evt) begin
      case (action)
        TCM_ACT_TOGGLE: begin
          out_bit <= ~out_bit;
        end
        TCM_ACT_CLEAR: begin
          out_bit <= buffered ? 1'b0 : 1'b0;
        end
        TCM_ACT_SET: begin
          out_bit <= 1'b1;
        end
        default: begin
          out_bit <= out_bit;
        end
      endcase
    end else if (bottom_evt) begin
      // PWM: non-inverting sets at BOTTOM, inverting clears
      if (action == TCM_ACT_CLEAR) begin
        out_bit <= 1'b1;
      end else if (action == TCM_ACT_SET) begin
        out_bit <= 1'b0;
      end
    end
  end

endmodule

// file: tcm_timer.sv
// Top of the 16-bit compare timer: counter, byte port, flags and pin override
`timescale 1ns/100ps
module tcm_timer import tcm_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire tcm_bus_req_t bus_req,
  output logic [7:0] read_data,
  input wire logic count_tick,
  input wire tcm_flags_t irq_ack,
  input wire logic [1:0] port_out_value,
  input wire logic [1:0] pin_direction_bit,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] compare_output_bit,
  output logic irq_request
);

  // ****************************************
  // Control state
  // ****************************************
  logic [1:0] act_a_reg; // Channel A output action
  logic [1:0] act_b_reg; // Channel B output action
  logic [3:0] mode_reg; // Waveform mode select
  logic run_reg; // Timer clock gate
  tcm_flags_t irq_en_reg; // Interrupt enables
  tcm_flags_t flag_reg; // Sticky event flags
  tcm_flags_t flag_next;
  logic [15:0] count_reg; // Timer count
  logic [15:0] cap_reg; // Capture value, used here only as TOP
  logic [7:0] temp_reg; // Shared high-byte latch
  logic block_reg; // Match blocking after counter write
  logic [7:0] rd_mux;

  // ****************************************
  // Decoded strobes
  // ****************************************
  logic wr_ctrl_a, wr_ctrl_b, wr_force, wr_irq_en, wr_flags;
  logic wr_cnt_lo, wr_cmpa_lo, wr_cmpb_lo, wr_cap_lo, wr_any_hi;
  logic rd_cnt_lo, rd_cap_lo;

  assign wr_ctrl_a = bus_req.wr && (bus_req.addr == TCM_OFF_CTRL_A);
  assign wr_ctrl_b = bus_req.wr && (bus_req.addr == TCM_OFF_CTRL_B);
  assign wr_force = bus_req.wr && (bus_req.addr == TCM_OFF_FORCE);
  assign wr_irq_en = bus_req.wr && (bus_req.addr == TCM_OFF_IRQ_EN);
  assign wr_flags = bus_req.wr && (bus_req.addr == TCM_OFF_FLAGS);
  assign wr_cnt_lo = bus_req.wr && (bus_req.addr == TCM_OFF_CNT_L);
  assign wr_cmpa_lo = bus_req.wr && (bus_req.addr == TCM_OFF_CMPA_L);
  assign wr_cmpb_lo = bus_req.wr && (bus_req.addr == TCM_OFF_CMPB_L);
  assign wr_cap_lo = bus_req.wr && (bus_req.addr == TCM_OFF_CAP_L);
  // Every high-byte location shares one latch
  assign wr_any_hi = bus_req.wr && ((bus_req.addr == TCM_OFF_CNT_H) || (bus_req.addr == TCM_OFF_CMPA_H)
    || (bus_req.addr == TCM_OFF_CMPB_H) || (bus_req.addr == TCM_OFF_CAP_H));
  assign rd_cnt_lo = bus_req.rd && (bus_req.addr == TCM_OFF_CNT_L);
  assign rd_cap_lo = bus_req.rd && (bus_req.addr == TCM_OFF_CAP_L);

  // Word formed by a low-byte write: latch above, bus byte below
  logic [15:0] wr_word;
  assign wr_word = {temp_reg, bus_req.wdata};

  // ****************************************
  // Mode decode and TOP selection
  // ****************************************
  logic pwm_mode; // Any of the twelve PWM modes
  logic var_top; // TOP comes from a register
  logic [15:0] top_value;
  logic [15:0] cmpa_active, cmpb_active, cmpa_view, cmpb_view;
  logic eq_a, eq_b, oc_a, oc_b;

  // Modes 0, 4, 12 and the reserved 13 are the non-PWM set
  assign pwm_mode = !((mode_reg == TCM_MODE_NORMAL) || (mode_reg == TCM_MODE_CTC_CMPA)
    || (mode_reg == TCM_MODE_CTC_CAP) || (mode_reg == TCM_MODE_RESERVED));

  // TOP per mode; phase-correct modes are folded onto up-counting here
  always_comb begin
    var_top = 1'b1;
    case (mode_reg)
      4'h1, 4'h5: begin
        top_value = TCM_TOP_8BIT;
        var_top = 1'b0;
      end
      4'h2, 4'h6: begin
        top_value = TCM_TOP_9BIT;
        var_top = 1'b0;
      end
      4'h3, 4'h7: begin
        top_value = TCM_TOP_10BIT;
        var_top = 1'b0;
      end
      4'h4, 4'h9, 4'hb, 4'hf: begin
        top_value = cmpa_active;
      end
      4'h8, 4'ha, 4'hc, 4'he: begin
        top_value = cap_reg;
      end
      default: begin
        top_value = TCM_COUNT_MAX;
        var_top = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Tick qualification
  // ****************************************
  logic tick_run; // Timer clock edge while running
  logic tick_live; // Tick not overridden by a counter write
  logic top_hit; // TOP reached and not blocked
  logic wrap_clear; // Counter clears at this tick
  logic match_a_evt, match_b_evt;

  assign tick_run = count_tick && run_reg;
  assign tick_live = tick_run && !wr_cnt_lo;
  // A blocked variable TOP is missed and counting runs on to MAX
  assign top_hit = (count_reg == top_value) && !(var_top && block_reg);
  assign wrap_clear = tick_live && top_hit && (mode_reg != TCM_MODE_NORMAL)
    && (mode_reg != TCM_MODE_RESERVED);
  assign match_a_evt = tick_live && !block_reg && eq_a;
  assign match_b_evt = tick_live && !block_reg && eq_b;

  // ****************************************
  // Compare channels
  // ****************************************
  tcm_compare_channel #(.WIDTH(16)) u_chan_a (
    .clock(clock),
    .reset(reset),
    .wr_en(wr_cmpa_lo),
    .wr_data(wr_word),
    .buffered(pwm_mode),
    .reload(wrap_clear && pwm_mode),
    .count(count_reg),
    .match_evt(match_a_evt),
    .force_evt(wr_force && bus_req.wdata[TCM_FORCE_A_POS] && !pwm_mode),
    .bottom_evt(wrap_clear && pwm_mode),
    .action(act_a_reg),
    .active_value(cmpa_active),
    .cpu_view(cmpa_view),
    .equal(eq_a),
    .out_bit(oc_a)
  );

  tcm_compare_channel #(.WIDTH(16)) u_chan_b (
    .clock(clock),
    .reset(reset),
    .wr_en(wr_cmpb_lo),
    .wr_data(wr_word),
    .buffered(pwm_mode),
    .reload(wrap_clear && pwm_mode),
    .count(count_reg),
    .match_evt(match_b_evt),
    .force_evt(wr_force && bus_req.wdata[TCM_FORCE_B_POS] && !pwm_mode),
    .bottom_evt(wrap_clear && pwm_mode),
    .action(act_b_reg),
    .active_value(cmpb_active),
    .cpu_view(cmpb_view),
    .equal(eq_b),
    .out_bit(oc_b)
  );

  // ****************************************
  // Control registers
  // ****************************************
  // Mode change leaves the output bits alone
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      act_a_reg <= TCM_ACT_NONE;
      act_b_reg <= TCM_ACT_NONE;
      mode_reg <= TCM_MODE_NORMAL;
      run_reg <= 1'b0;
      irq_en_reg <= '0;
    end else begin
      if (wr_ctrl_a) begin
        act_a_reg <= bus_req.wdata[TCM_ACT_A_POS +: 2];
        act_b_reg <= bus_req.wdata[TCM_ACT_B_POS +: 2];
        mode_reg[1:0] <= bus_req.wdata[TCM_MODE_LO_POS +: 2];
      end
      if (wr_ctrl_b) begin
        mode_reg[3:2] <= bus_req.wdata[TCM_MODE_HI_POS +: 2];
        run_reg <= bus_req.wdata[TCM_RUN_POS];
      end
      if (wr_irq_en) begin
        irq_en_reg <= tcm_flags_t'(bus_req.wdata[2:0]);
      end
    end
  end

  // Capture value is only written by software here; no capture path
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cap_reg <= TCM_RESET_WORD;
    end else if (wr_cap_lo) begin
      cap_reg <= wr_word;
    end
  end

  // ****************************************
  // Shared high-byte latch
  // ****************************************
  // High writes fill it; low reads of changing words snapshot it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      temp_reg <= TCM_RESET_BYTE;
    end else if (wr_any_hi) begin
      temp_reg <= bus_req.wdata;
    end else if (rd_cnt_lo) begin
      temp_reg <= count_reg[15:8];
    end else if (rd_cap_lo) begin
      temp_reg <= cap_reg[15:8];
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  // Software write wins over clear and count in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= TCM_RESET_WORD;
    end else if (wr_cnt_lo) begin
      count_reg <= wr_word;
    end else if (wrap_clear) begin
      count_reg <= TCM_COUNT_BOTTOM;
    end else if (tick_live) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Block holds until the next timer tick, even while stopped
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      block_reg <= 1'b0;
    end else if (wr_cnt_lo) begin
      block_reg <= 1'b1;
    end else if (tick_run) begin
      block_reg <= 1'b0;
    end
  end

  // ****************************************
  // Flags and interrupt request
  // ****************************************
  logic ovf_evt;
  // Overflow: MAX to zero outside PWM, TOP inside PWM
  assign ovf_evt = pwm_mode ? wrap_clear : (tick_live && (count_reg == TCM_COUNT_MAX));

  // Set wins over clear so no event is lost to a concurrent clear
  always_comb begin
    flag_next = flag_reg;
    if (wr_flags) begin
      flag_next = flag_next & ~tcm_flags_t'(bus_req.wdata[2:0]);
    end
    flag_next = flag_next & ~irq_ack;
    if (ovf_evt) begin
      flag_next.ovf = 1'b1;
    end
    if (match_a_evt) begin
      flag_next.match_a = 1'b1;
    end
    if (match_b_evt) begin
      flag_next.match_b = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Request from registered flags; one cycle behind the flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= |(flag_reg & irq_en_reg);
    end
  end

  // ****************************************
  // Pin override
  // ****************************************
  // Direction stays with the port; only the value is replaced
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_out <= 2'b00;
      pin_oe <= 2'b00;
      compare_output_bit <= 2'b00;
    end else begin
      pin_out[0] <= (act_a_reg != TCM_ACT_NONE) ? oc_a : port_out_value[0];
      pin_out[1] <= (act_b_reg != TCM_ACT_NONE) ? oc_b : port_out_value[1];
      pin_oe <= pin_direction_bit;
      compare_output_bit <= {oc_b, oc_a};
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Compare highs read direct; counter and capture highs via latch
  always_comb begin
    case (bus_req.addr)
      TCM_OFF_CTRL_A: rd_mux = {act_a_reg, act_b_reg, 2'b00, mode_reg[1:0]};
      TCM_OFF_CTRL_B: rd_mux = {3'b000, mode_reg[3:2], 2'b00, run_reg};
      TCM_OFF_IRQ_EN: rd_mux = {5'b00000, irq_en_reg};
      TCM_OFF_FLAGS: rd_mux = {5'b00000, flag_reg};
      TCM_OFF_CNT_L: rd_mux = count_reg[7:0];
      TCM_OFF_CNT_H: rd_mux = temp_reg;
      TCM_OFF_CMPA_L: rd_mux = cmpa_view[7:0];
      TCM_OFF_CMPA_H: rd_mux = cmpa_view[15:8];
      TCM_OFF_CMPB_L: rd_mux = cmpb_view[7:0];
      TCM_OFF_CMPB_H: rd_mux = cmpb_view[15:8];
      TCM_OFF_CAP_L: rd_mux = cap_reg[7:0];
      TCM_OFF_CAP_H: rd_mux = temp_reg;
      default: rd_mux = TCM_RESET_BYTE; // Force and unmapped read zero
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data <= TCM_RESET_BYTE;
    end else begin
      read_data <= bus_req.rd ? rd_mux : TCM_RESET_BYTE;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_match_sets_flag: assert property (@(posedge clock) disable iff (reset)
    (tick_run && !wr_cnt_lo && !block_reg && count_reg == cmpa_active) |=> flag_reg.match_a)
    else $error("match did not set flag A");

  a_write_blocks_match: assert property (@(posedge clock) disable iff (reset)
    wr_cnt_lo |=> (block_reg && !match_a_evt && !match_b_evt))
    else $error("match not blocked after counter write");

  a_write_priority: assert property (@(posedge clock) disable iff (reset)
    wr_cnt_lo |=> (count_reg == $past(wr_word)))
    else $error("counter write lost");

  a_normal_wrap: assert property (@(posedge clock) disable iff (reset)
    (mode_reg == TCM_MODE_NORMAL && tick_live && count_reg == TCM_COUNT_MAX)
    |=> (count_reg == TCM_COUNT_BOTTOM && flag_reg.ovf))
    else $error("normal wrap or overflow wrong");

  a_ctc_clear: assert property (@(posedge clock) disable iff (reset)
    (mode_reg == TCM_MODE_CTC_CMPA && tick_live && !block_reg && count_reg == cmpa_active)
    |=> (count_reg == TCM_COUNT_BOTTOM))
    else $error("clear on match missed");

  a_buffer_holds: assert property (@(posedge clock) disable iff (reset)
    (pwm_mode && !wrap_clear) |=> (cmpa_active == $past(cmpa_active)))
    else $error("active compare changed off TOP");

  a_action_zero: assert property (@(posedge clock) disable iff (reset)
    (act_a_reg == TCM_ACT_NONE && !(wrap_clear && pwm_mode)) |=> $stable(oc_a))
    else $error("output moved with action zero");

  a_force_no_flag: assert property (@(posedge clock) disable iff (reset)
    (wr_force && !match_a_evt && !flag_reg.match_a && !irq_ack.match_a) |=> !flag_reg.match_a)
    else $error("force set the flag");

  a_pin_override: assert property (@(posedge clock) disable iff (reset)
    (act_b_reg != TCM_ACT_NONE) |=> (pin_out[1] == $past(oc_b) && pin_oe == $past(pin_direction_bit)))
    else $error("pin override wrong");

  a_flag_clear: assert property (@(posedge clock) disable iff (reset)
    (wr_flags && bus_req.wdata[0] && !ovf_evt) |=> !flag_reg.ovf)
    else $error("write one did not clear flag");

endmodule

// file: tcm_cpu_model.sv
// Processor core model driving the timer byte port
`timescale 1ns/100ps
module tcm_cpu_model import tcm_pkg::*; (
  input wire logic clock,
  input wire logic [7:0] read_data,
  output tcm_bus_req_t bus_req
);
  // ****
  // Bus cycles
  // ****
  initial bus_req = '0; // Idle port at time zero
  // One write, strobe held to the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  // One read, data valid only in the next cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = read_data;
  endtask
  // Word write: high byte first fills the shared latch
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the 16-bit compare timer
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb import tcm_pkg::*; ;
  logic clock = 0, reset = 1, count_tick = 0;
  tcm_bus_req_t bus_req;
  tcm_flags_t irq_ack = '0;
  logic [7:0] read_data, d;
  logic [1:0] port_out_value = 2'b10, pin_direction_bit = 2'b00;
  logic [1:0] pin_out, pin_oe, compare_output_bit;
  logic irq_request;
  int n_errors = 0, num_checks = 0;
  always #5 clock = ~clock; // 100 MHz
  tcm_cpu_model cpu (.clock(clock), .read_data(read_data), .bus_req(bus_req));
  tcm_timer uut (.clock(clock), .reset(reset), .bus_req(bus_req), .read_data(read_data),
    .count_tick(count_tick), .irq_ack(irq_ack), .port_out_value(port_out_value),
    .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe(pin_oe),
    .compare_output_bit(compare_output_bit), .irq_request(irq_request));
  // ****
  // Helpers
  // ****
  // One timer clock pulse
  task automatic tick();
    @(posedge clock) count_tick <= 1'b1;
    @(posedge clock) count_tick <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  // Outputs after reset; idle action lets the port value through
  task automatic t_reset();
    `CHK("obit", 2'b00, compare_output_bit)
    `CHK("pin", 2'b10, pin_out)
  endtask
  // Word write through latch, high byte read directly
  task automatic t_word();
    cpu.wr16(TCM_OFF_CMPB_L, 16'h1234);
    cpu.rd(TCM_OFF_CMPB_H, d); `CHK("cmph", 8'h12, d)
    cpu.rd(TCM_OFF_CMPB_L, d); `CHK("cmpl", 8'h34, d)
  endtask
  // Clear-on-match with toggle, flag, interrupt and ack
  task automatic t_ctc();
    @(posedge clock) pin_direction_bit <= 2'b01;
    cpu.wr(TCM_OFF_CTRL_A, 8'h40); // Toggle on A, mode low 00
    cpu.wr16(TCM_OFF_CMPA_L, 16'h0002);
    cpu.wr(TCM_OFF_IRQ_EN, 8'h02);
    cpu.wr(TCM_OFF_CTRL_B, 8'h09); // Mode 4, run
    tick(); tick();
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("flag0", 8'h00, d)
    tick();
    cpu.rd(TCM_OFF_CNT_L, d); `CHK("cnt", 8'h00, d)
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("flag1", 8'h02, d)
    `CHK("obit", 2'b01, compare_output_bit)
    `CHK("pin", 2'b11, pin_out)
    `CHK("oe", 2'b01, pin_oe)
    `CHK("irq", 1'b1, irq_request)
    @(posedge clock) irq_ack <= '{1'b0, 1'b1, 1'b0};
    @(posedge clock) irq_ack <= '0;
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("ack", 8'h00, d)
  endtask
  // Mode change keeps output; force clears it without a flag
  task automatic t_force();
    cpu.wr(TCM_OFF_CTRL_B, 8'h00);
    `CHK("keep", 2'b01, compare_output_bit)
    cpu.wr(TCM_OFF_CTRL_A, 8'h80);
    cpu.wr(TCM_OFF_FORCE, 8'h80);
    repeat (2) @(posedge clock);
    `CHK("force", 2'b00, compare_output_bit)
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("fflag", 8'h00, d)
  endtask
  // Counter write hides the next match; then wrap and overflow
  task automatic t_block_wrap();
    cpu.wr(TCM_OFF_CTRL_A, 8'h40);
    cpu.wr16(TCM_OFF_CMPA_L, 16'h0005);
    cpu.wr16(TCM_OFF_CNT_L, 16'h0005);
    cpu.wr(TCM_OFF_CTRL_B, 8'h01); // Normal, run
    tick();
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("blk", 8'h00, d)
    `CHK("bobit", 2'b00, compare_output_bit)
    cpu.wr16(TCM_OFF_CNT_L, 16'hfffe);
    tick(); tick();
    cpu.rd(TCM_OFF_CNT_L, d); `CHK("wrapl", 8'h00, d)
    cpu.rd(TCM_OFF_CNT_H, d); `CHK("wraph", 8'h00, d)
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("ovf", 8'h01, d)
    cpu.wr(TCM_OFF_FLAGS, 8'h01);
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("w1c", 8'h00, d)
  endtask
  // PWM with TOP from capture: compare writes wait in the buffer until the wrap
  task automatic t_pwm();
    cpu.wr16(TCM_OFF_CAP_L, 16'h0003);
    cpu.wr(TCM_OFF_CTRL_A, 8'h22); // Clear B on match, mode low 10
    cpu.wr16(TCM_OFF_CMPA_L, 16'h0001);
    cpu.wr16(TCM_OFF_CMPB_L, 16'h0002);
    cpu.rd(TCM_OFF_CMPB_L, d); `CHK("bufl", 8'h02, d)
    cpu.rd(TCM_OFF_CMPB_H, d); `CHK("bufh", 8'h00, d)
    cpu.wr(TCM_OFF_CTRL_B, 8'h19); // Mode 14, run
    repeat (3) tick();
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("pflag0", 8'h00, d)
    tick();
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("povf", 8'h01, d)
    `CHK("pset", 2'b10, compare_output_bit)
    repeat (3) tick();
    cpu.rd(TCM_OFF_FLAGS, d); `CHK("pflag1", 8'h07, d)
    `CHK("pclr", 2'b00, compare_output_bit)
    `CHK("ppin", 2'b00, pin_out)
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    t_reset();
    t_word();
    t_ctc();
    t_force();
    t_block_wrap();
    t_pwm();
    complete_run();
  end
  // Whole run needs well under 400 cycles
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule
